// ### core/afa_abs.sv
/*
 * Absolute-value stage for high-gain samples with saturation.
 * Assumes the stream comes registered from the filter stage.
 */
`timescale 1ns/1ps
`default_nettype none

module afa_abs (
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // Settings
    input  wire logic              enable,
    // Streams
    afa_samp_if.snk                s_in,
    afa_samp_if.src                s_out
);
    import afa_pkg::*;

    logic      flip;
    afa_samp_t mag;

    always_comb begin
        flip = enable && !s_in.is_dc && s_in.data[15];
        mag  = afa_sat16(-17'(s_in.data));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_out.valid <= 1'b0;
            s_out.data  <= '0;
            s_out.chan  <= '0;
            s_out.is_dc <= 1'b0;
        end else if (ce) begin
            s_out.valid <= s_in.valid;
            if (s_in.valid) begin
                s_out.data  <= flip ? mag : s_in.data;
                s_out.chan  <= s_in.chan;
                s_out.is_dc <= s_in.is_dc;
            end
        end
    end

    property p_abs_min;
        @(posedge pclk) disable iff (!presetn || !ce)
        s_in.valid && enable && !s_in.is_dc && s_in.data == `AFA_SAMP_MIN
            |=> s_out.data == `AFA_SAMP_MAX;
    endproperty
    a_abs_min: assert property (p_abs_min)
        else $error("most negative sample wrapped");

endmodule // afa_abs

`default_nettype wire

// ### core/afa_aux_ctrl.sv
/*
 * Top of the auxiliary output, fault detect and absolute-value block:
 * APB register slave, pin control, fault synchroniser, event flags and
 * the two-stage sample path.
 * Assumes an APB master on pclk, samples from logic on pclk and a fault
 * comparator output that is asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "afa_params.svh"

module afa_aux_ctrl (
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire afa_pkg::afa_addr_t paddr,
    input  wire afa_pkg::afa_word_t pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Fault comparator, asynchronous
    input  wire logic              fault_cmp_in,
    // Samples from the converter
    input  wire logic              samp_valid,
    input  wire afa_pkg::afa_samp_t samp_data,
    input  wire afa_pkg::afa_chan_t samp_chan,
    input  wire logic              samp_is_dc,
    input  wire logic              samp_hpf_clear,
    // Returned results
    output logic                   res_valid,
    output afa_pkg::afa_samp_t     res_data,
    output afa_pkg::afa_chan_t     res_chan,
    output logic                   res_is_dc,
    // Auxiliary pins
    output logic                   push_pull_out_a_o,
    output logic                   push_pull_out_a_oe,
    output logic                   push_pull_out_b_o,
    output logic                   push_pull_out_b_oe,
    output logic                   open_drain_out_o,
    output logic                   open_drain_out_oe,
    // Interrupt
    output logic                   irq
);
    import afa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [`AFA_CTRL_W-1:0]   ctrl_r;
    logic [`AFA_CUTOFF_W-1:0] cutoff_r;
    logic [`AFA_IRQ_W-1:0]    irq_stat_r;
    logic [`AFA_IRQ_W-1:0]    irq_stat_nxt;
    logic [`AFA_IRQ_W-1:0]    irq_en_r;
    logic [`AFA_IRQ_W-1:0]    irq_set;
    logic [`AFA_IRQ_W-1:0]    irq_clr;
    logic                     fault_meta_r;
    logic                     fault_sync_r;
    logic [31:0]              prdata_r;
    logic [31:0]              rdata_nxt;
    logic [7:0]               idx;
    logic                     aligned;
    logic                     mapped;
    logic                     setup;
    logic                     wr_acc;
    logic                     wr_ctrl;
    logic                     wr_cutoff;
    logic                     wr_clr;
    logic                     wr_en;

    afa_samp_if s_raw ();
    afa_samp_if s_filt ();
    afa_samp_if s_out ();

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    function automatic logic afa_known(input logic [7:0] i);
        case (i)
            `AFA_IDX_CTRL,
            `AFA_IDX_CUTOFF,
            `AFA_IDX_FAULT,
            `AFA_IDX_STAT,
            `AFA_IDX_CLR,
            `AFA_IDX_EN,
            `AFA_IDX_RES:    return 1'b1;
            default:         return 1'b0;
        endcase
    endfunction

    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == '0);
    assign mapped  = aligned && afa_known(idx);
    assign setup   = ce && psel && !penable;

    // Clock enable low stretches the access phase instead of losing it
    assign pready  = ce;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_r;

    assign wr_acc    = ce && psel && penable && pwrite && mapped;
    assign wr_ctrl   = wr_acc && (idx == `AFA_IDX_CTRL);
    assign wr_cutoff = wr_acc && (idx == `AFA_IDX_CUTOFF);
    assign wr_clr    = wr_acc && (idx == `AFA_IDX_CLR);
    assign wr_en     = wr_acc && (idx == `AFA_IDX_EN);

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    always_comb begin
        rdata_nxt = '0;
        if (aligned) begin
            case (idx)
                `AFA_IDX_CTRL:   rdata_nxt = 32'(ctrl_r);
                `AFA_IDX_CUTOFF: rdata_nxt = 32'(cutoff_r);
                `AFA_IDX_FAULT:  rdata_nxt = 32'({fault_sync_r,
                                                  irq_stat_r[`AFA_IRQ_FAULT]});
                `AFA_IDX_STAT:   rdata_nxt = 32'(irq_stat_r);
                `AFA_IDX_EN:     rdata_nxt = 32'(irq_en_r);
                `AFA_IDX_RES:    rdata_nxt = 32'({res_chan, res_is_dc, res_data});
                default:         rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup && !pwrite) begin
            prdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `AFA_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[`AFA_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cutoff_r <= `AFA_CUTOFF_RST;
        end else if (wr_cutoff) begin
            cutoff_r <= pwdata[`AFA_CUTOFF_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= '0;
        end else if (wr_en) begin
            irq_en_r <= pwdata[`AFA_IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary pins

    assign push_pull_out_a_oe = !ctrl_r[`AFA_CTRL_A_TRI];
    assign push_pull_out_b_oe = !ctrl_r[`AFA_CTRL_B_TRI];
    assign push_pull_out_a_o  = ctrl_r[`AFA_CTRL_A_VAL];
    assign push_pull_out_b_o  = ctrl_r[`AFA_CTRL_B_VAL];
    assign open_drain_out_o   = 1'b0;
    assign open_drain_out_oe  = ctrl_r[`AFA_CTRL_OD_VAL];

    ////////////////////////////////////////////////////////////////////////
    // Fault comparator synchroniser

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_meta_r <= 1'b0;
            fault_sync_r <= 1'b0;
        end else if (ce) begin
            fault_meta_r <= fault_cmp_in;
            fault_sync_r <= fault_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags and interrupt

    // A fault that persists keeps its flag set against clears
    always_comb begin
        irq_set = '0;
        irq_set[`AFA_IRQ_FAULT]  = fault_sync_r;
        irq_set[`AFA_IRQ_RESULT] = s_out.valid;
        irq_clr      = wr_clr ? pwdata[`AFA_IRQ_W-1:0] : '0;
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else if (ce) begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////////
    // Sample path: filter, then absolute value

    assign s_raw.valid = samp_valid;
    assign s_raw.data  = samp_data;
    assign s_raw.chan  = samp_chan;
    assign s_raw.is_dc = samp_is_dc;

    afa_hpf u_hpf (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (ctrl_r[`AFA_CTRL_HPF]),
        .cutoff  (cutoff_r),
        .clear   (samp_hpf_clear),
        .s_in    (s_raw),
        .s_out   (s_filt)
    );

    afa_abs u_abs (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (ctrl_r[`AFA_CTRL_ABS]),
        .s_in    (s_filt),
        .s_out   (s_out)
    );

    assign res_valid = s_out.valid;
    assign res_data  = s_out.data;
    assign res_chan  = s_out.chan;
    assign res_is_dc = s_out.is_dc;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_fault_held;
        fault_cmp_in [*3];
    endsequence

    property p_fault_flag;
        @(posedge pclk) disable iff (!presetn || !ce)
        s_fault_held |=> irq_stat_r[`AFA_IRQ_FAULT];
    endproperty
    a_fault_flag: assert property (p_fault_flag)
        else $error("fault current did not set the fault flag");

    property p_fault_sticky;
        @(posedge pclk) disable iff (!presetn || !ce)
        irq_stat_r[`AFA_IRQ_FAULT] && !wr_clr |=> irq_stat_r[`AFA_IRQ_FAULT];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault flag dropped without a clear");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> ctrl_r == $past(pwdata[`AFA_CTRL_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");

    property p_ctrl_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_ctrl |=> $stable(ctrl_r);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("pin control changed without a write");

    property p_pin_a_drive;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && !pwdata[`AFA_CTRL_A_TRI]
            |=> push_pull_out_a_oe
                && push_pull_out_a_o == $past(pwdata[`AFA_CTRL_A_VAL]);
    endproperty
    a_pin_a_drive: assert property (p_pin_a_drive)
        else $error("pin a not driven to its value");

    property p_pin_b_release;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && pwdata[`AFA_CTRL_B_TRI] |=> !push_pull_out_b_oe;
    endproperty
    a_pin_b_release: assert property (p_pin_b_release)
        else $error("pin b not released");

    property p_pin_a_release;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && pwdata[`AFA_CTRL_A_TRI] |=> !push_pull_out_a_oe;
    endproperty
    a_pin_a_release: assert property (p_pin_a_release)
        else $error("pin a not released");

    property p_pin_b_drive;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && !pwdata[`AFA_CTRL_B_TRI]
            |=> push_pull_out_b_oe
                && push_pull_out_b_o == $past(pwdata[`AFA_CTRL_B_VAL]);
    endproperty
    a_pin_b_drive: assert property (p_pin_b_drive)
        else $error("pin b not driven to its value");

    property p_fault_clear;
        @(posedge pclk) disable iff (!presetn || !ce)
        wr_clr && pwdata[`AFA_IRQ_FAULT] && !fault_sync_r
            |=> !irq_stat_r[`AFA_IRQ_FAULT];
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault flag survived a clear without a fault");

    property p_open_drain;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> open_drain_out_oe == $past(pwdata[`AFA_CTRL_OD_VAL])
                    && !open_drain_out_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain switch wrong");

    sequence s_neg_high_gain;
        samp_valid && !samp_is_dc && !wr_ctrl && samp_data[15]
            && ctrl_r[`AFA_CTRL_ABS] && !ctrl_r[`AFA_CTRL_HPF]
            && samp_data != `AFA_SAMP_MIN;
    endsequence

    property p_abs_negate;
        @(posedge pclk) disable iff (!presetn || !ce)
        s_neg_high_gain
            |-> ##2 res_valid && res_data == -$past(samp_data, 2);
    endproperty
    a_abs_negate: assert property (p_abs_negate)
        else $error("negative high-gain result not inverted");

    property p_dc_passes;
        @(posedge pclk) disable iff (!presetn || !ce)
        samp_valid && samp_is_dc
            |-> ##2 res_valid && res_is_dc && res_data == $past(samp_data, 2);
    endproperty
    a_dc_passes: assert property (p_dc_passes)
        else $error("low-gain result was modified");

endmodule // afa_aux_ctrl

`default_nettype wire

// ### core/afa_hpf.sv
/*
 * Single-pole high-pass offset removal on high-gain samples, one state
 * word per channel. Assumes samples arrive from logic on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module afa_hpf (
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // Settings
    input  wire logic              enable,
    input  wire logic [3:0]        cutoff,
    input  wire logic              clear,
    // Streams
    afa_samp_if.snk                s_in,
    afa_samp_if.src                s_out
);
    import afa_pkg::*;

    logic signed [31:0] state_mem [0:`AFA_NCHAN-1];
    logic signed [31:0] acc_cur;
    logic signed [31:0] acc_nxt;
    logic signed [16:0] diff;
    afa_samp_t          y;
    logic               apply;

    // Cutoff zero moves the baseline fully, giving a differentiator
    always_comb begin
        apply   = enable && !s_in.is_dc;
        acc_cur = clear ? '0 : state_mem[s_in.chan];
        diff    = 17'(s_in.data) - 17'($signed(acc_cur[31:16]));
        y       = afa_sat16(diff);
        acc_nxt = acc_cur + ($signed({y, 16'h0000}) >>> cutoff);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `AFA_NCHAN; i++) begin
                state_mem[i] <= '0;
            end
        end else if (ce && s_in.valid && (apply || clear)) begin
            state_mem[s_in.chan] <= apply ? acc_nxt : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_out.valid <= 1'b0;
            s_out.data  <= '0;
            s_out.chan  <= '0;
            s_out.is_dc <= 1'b0;
        end else if (ce) begin
            s_out.valid <= s_in.valid;
            if (s_in.valid) begin
                s_out.data  <= apply ? y : s_in.data;
                s_out.chan  <= s_in.chan;
                s_out.is_dc <= s_in.is_dc;
            end
        end
    end

    property p_hpf_bypass;
        @(posedge pclk) disable iff (!presetn || !ce)
        s_in.valid && !enable |=> s_out.data == $past(s_in.data);
    endproperty
    a_hpf_bypass: assert property (p_hpf_bypass)
        else $error("filter altered a sample while disabled");

    property p_hpf_cleared;
        @(posedge pclk) disable iff (!presetn || !ce)
        s_in.valid && enable && clear && !s_in.is_dc
            |=> s_out.data == $past(s_in.data);
    endproperty
    a_hpf_cleared: assert property (p_hpf_cleared)
        else $error("cleared filter did not start from zero");

endmodule // afa_hpf

`default_nettype wire

// ### include/afa_params.svh
/*
 * Constants for the auxiliary output, fault and absolute-value block:
 * register indices, field positions, reset values and widths.
 * Assumes an APB slave with 32-bit data and word indices times four as
 * byte addresses.
 */
`ifndef AFA_PARAMS_SVH
`define AFA_PARAMS_SVH

// Register word indices, byte address is index times four
`define AFA_IDX_CTRL     8'h01
`define AFA_IDX_CUTOFF   8'h04
`define AFA_IDX_FAULT    8'h32
`define AFA_IDX_STAT     8'h40
`define AFA_IDX_CLR      8'h41
`define AFA_IDX_EN       8'h42
`define AFA_IDX_RES      8'h43

// Control register fields
`define AFA_CTRL_W       7
`define AFA_CTRL_A_VAL   0
`define AFA_CTRL_A_TRI   1
`define AFA_CTRL_B_VAL   2
`define AFA_CTRL_B_TRI   3
`define AFA_CTRL_OD_VAL  4
`define AFA_CTRL_ABS     5
`define AFA_CTRL_HPF     6
`define AFA_CTRL_RST     7'h0A
`define AFA_CUTOFF_W     4
`define AFA_CUTOFF_RST   4'h0

// Fault register fields
`define AFA_FAULT_LATCH  0
`define AFA_FAULT_LIVE   1

// Event status, clear and enable fields
`define AFA_IRQ_W        2
`define AFA_IRQ_FAULT    0
`define AFA_IRQ_RESULT   1

// Sample path
`define AFA_NCHAN        16
`define AFA_SAMP_MAX     16'h7FFF
`define AFA_SAMP_MIN     16'h8000

`endif

// ### include/afa_pkg.sv
/*
 * Types and shared arithmetic of the auxiliary output block.
 * Assumes afa_params.svh is on the include path.
 */
`include "afa_params.svh"

`default_nettype none

package afa_pkg;

    typedef logic signed [15:0] afa_samp_t;
    typedef logic [3:0]         afa_chan_t;
    typedef logic [9:0]         afa_addr_t;
    typedef logic [31:0]        afa_word_t;

    // Clamp a 17-bit result to 16 bits instead of letting it wrap
    function automatic afa_samp_t afa_sat16(input logic signed [16:0] v);
        if (v[16] != v[15]) begin
            return v[16] ? `AFA_SAMP_MIN : `AFA_SAMP_MAX;
        end
        return v[15:0];
    endfunction

endpackage

`default_nettype wire

// ### include/afa_samp_if.sv
/*
 * Sample stream between the filter and absolute-value stages.
 * Assumes one clock shared by both ends; valid marks a one-cycle sample.
 */
`timescale 1ns/1ps
`default_nettype none

interface afa_samp_if;
    import afa_pkg::*;
    logic      valid;
    afa_samp_t data;
    afa_chan_t chan;
    logic      is_dc;
    modport src (output valid, output data, output chan, output is_dc);
    modport snk (input valid, input data, input chan, input is_dc);
endinterface

`default_nettype wire

// ### tb/afa_apb_model.sv
/*
 * APB master standing in for the controller that programs the block.
 * Assumes the slave shares pclk and answers through pready.
 */
`timescale 1ns/1ps
`default_nettype none

module afa_apb_model (
    // Clock
    input  wire logic               pclk,
    // Requests
    output logic                    psel,
    output logic                    penable,
    output logic                    pwrite,
    output afa_pkg::afa_addr_t      paddr,
    output afa_pkg::afa_word_t      pwdata,
    // Answers
    input  wire logic [31:0]        prdata,
    input  wire logic               pready,
    input  wire logic               pslverr
);
    import afa_pkg::*;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // Request held until pready is seen high; only the bench timeout ends a wait
    task automatic xfer(input logic wr, input afa_addr_t a, input afa_word_t d,
                        output afa_word_t rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // afa_apb_model

`default_nettype wire

// ### tb/afa_aux_ctrl_tb_top.sv
/*
 * Self-checking bench for the auxiliary output, fault and sample block.
 * Assumes afa_params.svh on the include path and the APB model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

`include "afa_params.svh"

module afa_aux_ctrl_tb_top;
    import afa_pkg::*;

    logic pclk = 1'b0, presetn, fault_cmp_in, samp_valid, samp_is_dc, samp_hpf_clear;
    logic psel, penable, pwrite, pready, pslverr, res_valid, res_is_dc, irq;
    logic pa_o, pa_oe, pb_o, pb_oe, od_o, od_oe, ce;
    afa_addr_t paddr;
    afa_word_t pwdata, rd;
    logic [31:0] prdata;
    afa_samp_t samp_data, res_data;
    afa_chan_t res_chan;
    logic er;
    int n_mismatch = 0, check_count = 0, cyc = 0;

    // {ctrl, expected {od_o, od_oe, b_oe, b_oe&b_o, a_oe, a_oe&a_o}}
    logic [15:0] pin_rows [5] = '{16'h000A, 16'h151F, 16'h0A00, 16'h050F, 16'h1218};
    // {ctrl, {dc, clear}, sample, expected result}
    logic [43:0] smp_rows [10] = '{
        44'h0A0FF9CFF9C, 44'h2A0FF9C0064, 44'h2A000640064, 44'h2A080007FFF,
        44'h2A2FF9CFF9C, 44'h4A103E803E8, 44'h4A00514012C, 44'h4A201F401F4,
        44'h6A1FFCE0032, 44'h4A0FFCE0000};

    always #5 pclk = ~pclk;

    afa_aux_ctrl afa_aux_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_cmp_in(fault_cmp_in),
        .samp_valid(samp_valid), .samp_data(samp_data), .samp_chan(4'h5),
        .samp_is_dc(samp_is_dc), .samp_hpf_clear(samp_hpf_clear), .res_valid(res_valid),
        .res_data(res_data), .res_chan(res_chan), .res_is_dc(res_is_dc),
        .push_pull_out_a_o(pa_o), .push_pull_out_a_oe(pa_oe), .push_pull_out_b_o(pb_o),
        .push_pull_out_b_oe(pb_oe), .open_drain_out_o(od_o), .open_drain_out_oe(od_oe),
        .irq(irq));

    afa_apb_model afa_apb_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////
    function automatic afa_addr_t ra(input logic [7:0] i);
        return {i, 2'b00};
    endfunction

    task automatic wrap_up();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] i, input afa_word_t d);
        afa_apb_model_i.xfer(1'b1, ra(i), d, rd, er);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] i, input afa_word_t exp);
        afa_apb_model_i.xfer(1'b0, ra(i), '0, rd, er);
        check({er, rd}, {1'b0, exp});
    endtask

    // Sample in, result exactly one cycle after it is taken
    task automatic run_row(input logic [43:0] r);
        int k;
        wr(`AFA_IDX_CTRL, {24'h0, r[43:36]});
        @(posedge pclk);
        samp_valid     <= 1'b1;
        samp_data      <= r[31:16];
        samp_is_dc     <= r[33];
        samp_hpf_clear <= r[32];
        @(posedge pclk);
        samp_valid     <= 1'b0;
        samp_hpf_clear <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            #1;
            k++;
        end while (res_valid !== 1'b1 && k < 8);
        check(k, 1);
        check({res_is_dc, res_chan, res_data},
              {r[33], 4'h5, r[15:0]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        fault_cmp_in = 1'b0;
        samp_valid = 1'b0;
        samp_data = '0;
        samp_is_dc = 1'b0;
        samp_hpf_clear = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check({pa_oe, pb_oe, od_oe, irq}, 4'h0);
        rd_chk(`AFA_IDX_CTRL, 32'h0A);
        rd_chk(`AFA_IDX_CUTOFF, 32'h0);
        // pins programmed before they are trusted
        foreach (pin_rows[i]) begin
            wr(`AFA_IDX_CTRL, {24'h0, pin_rows[i][15:8]});
            check({od_o, od_oe, pb_oe, pb_oe & pb_o, pa_oe, pa_oe & pa_o},
                  pin_rows[i][5:0]);
            rd_chk(`AFA_IDX_CTRL, {24'h0, pin_rows[i][15:8]});
        end
        foreach (smp_rows[i]) begin
            run_row(smp_rows[i]);
        end
        rd_chk(`AFA_IDX_RES, 32'h000A0000);
        rd_chk(`AFA_IDX_STAT, 32'h2);
        check(irq, 1'b0);
        wr(`AFA_IDX_EN, 32'h3);
        check(irq, 1'b1);
        rd_chk(`AFA_IDX_EN, 32'h3);
        wr(`AFA_IDX_CLR, 32'h2);
        check(irq, 1'b0);
        // Clock enable low freezes the fault path and holds pready low
        ce <= 1'b0;
        fault_cmp_in <= 1'b1;
        repeat (4) @(posedge pclk);
        check(pready, 1'b0);
        fault_cmp_in <= 1'b0;
        @(posedge pclk);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        check(irq, 1'b0);
        // fault polled while nothing else runs
        fault_cmp_in <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        check(irq, 1'b1);
        rd_chk(`AFA_IDX_FAULT, 32'h3);
        wr(`AFA_IDX_CLR, 32'h1);
        rd_chk(`AFA_IDX_STAT, 32'h1);
        fault_cmp_in <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(`AFA_IDX_CLR, 32'h1);
        rd_chk(`AFA_IDX_FAULT, 32'h0);
        check(irq, 1'b0);
        // Refused accesses leave the pins alone
        afa_apb_model_i.xfer(1'b0, 10'h3FC, '0, rd, er);
        check({er, rd}, {1'b1, 32'h0});
        afa_apb_model_i.xfer(1'b1, 10'h005, 32'h7F, rd, er);
        check(er, 1'b1);
        wr(`AFA_IDX_STAT, 32'h3);
        rd_chk(`AFA_IDX_STAT, 32'h0);
        rd_chk(`AFA_IDX_CTRL, 32'h4A);
        // Reset in mid-run releases the pins again
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check({pa_oe, pb_oe, od_oe, irq, res_valid, res_data}, 21'h0);
        rd_chk(`AFA_IDX_CTRL, 32'h0A);
        rd_chk(`AFA_IDX_EN, 32'h0);
        wrap_up();
    end
endmodule // afa_aux_ctrl_tb_top

`default_nettype wire
